//--- common/ack_params.svh
// Constants for the latched-indication acknowledge block
`ifndef ACK_PARAMS_SVH
`define ACK_PARAMS_SVH
`define ACK_CLK_HZ 125000000
`define ACK_HOLD_MS 1000
`define ACK_LAMP_MS 1000
`define ACK_REG_CTRL 8'h00
`define ACK_REG_LEDCFG 8'h04
`define ACK_REG_STATUS 8'h08
`define ACK_REG_IRQ_EN 8'h0C
`define ACK_REG_IRQ_CLR 8'h10
`define ACK_REG_LATCH 8'h14
`define ACK_REG_CMD 8'h18
`define ACK_CTRL_EXT_EN 0
`define ACK_CTRL_KEYSEL_LO 1
`define ACK_CTRL_PW_EMPTY 3
`define ACK_CTRL_RESET 32'h0000_0001
`define ACK_CMD_PW_OK 4
`define ACK_CMD_CONFIRM 5
`define ACK_CMD_REMOTE 6
`define ACK_IRQ_DONE 0
`define ACK_IRQ_REFUSED 1
`define ACK_IRQ_LAMP 2
`define ACK_IRQ_W 3
`endif

//--- common/ack_pkg.sv
// Types shared by the acknowledge block
package ack_pkg;
  typedef enum logic [1:0] {
    KEY_SEL_NONE = 2'b00,
    KEY_SEL_LEDS = 2'b01,
    KEY_SEL_LEDS_RELAYS = 2'b10,
    KEY_SEL_ALL = 2'b11
  } key_sel_t;

  typedef struct packed {
    logic leds;
    logic relays;
    logic scada;
    logic trip;
  } clear_set_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_PASS = 3'b011,
    ST_LAMP = 3'b010,
    ST_SELECT = 3'b110
  } ack_state_t;
endpackage : ack_pkg

//--- core/ack_latch_bank.sv
// One class of latched indications with acknowledge clearing
`timescale 1ns/100ps
module ack_latch_bank #(
  parameter int N = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] cause_i,
  input wire logic [N-1:0] clear_mask_i,
  input wire logic clear_i,
  output logic [N-1:0] latched_o
);
  logic [N-1:0] latched_r;
  logic [N-1:0] latched_nxt;

  // Cause wins over clear, so a still-active indication stays set
  always_comb begin
    latched_nxt = latched_r;
    if (clear_i) begin
      latched_nxt = latched_r & ~clear_mask_i;
    end
    latched_nxt = latched_nxt | cause_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_r <= '0;
    end else begin
      latched_r <= latched_nxt;
    end
  end

  assign latched_o = latched_r;
endmodule : ack_latch_bank

//--- core/latched_ack.sv
// Acknowledge control for latched LEDs, relays, SCADA indications and trip commands
`timescale 1ns/100ps
`include "ack_params.svh"
module latched_ack #(
  parameter int N_LED = 8,
  parameter int N_REL = 6,
  parameter int N_SCADA = 8,
  parameter int HOLD_CYC = (`ACK_CLK_HZ / 1000) * `ACK_HOLD_MS,
  parameter int LAMP_CYC = (`ACK_CLK_HZ / 1000) * `ACK_LAMP_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic clear_key_i,
  input wire logic edit_mode_i,
  input wire logic led_clear_source_i,
  input wire logic relay_clear_source_i,
  input wire logic scada_clear_source_i,
  input wire logic new_alarm_i,
  input wire logic [N_LED-1:0] led_cause_i,
  input wire logic [N_REL-1:0] relay_cause_i,
  input wire logic [N_SCADA-1:0] scada_cause_i,
  input wire logic trip_cause_i,
  output logic [N_LED-1:0] led_o,
  output logic lamp_red_o,
  output logic lamp_green_o,
  output logic [N_REL-1:0] relay_o,
  output logic [N_SCADA-1:0] scada_o,
  output logic trip_pending_o,
  output logic irq_o
);
  import ack_pkg::*;

  function automatic logic rising(input logic now, input logic was);
    rising = now & ~was;
  endfunction : rising

  // Pin synchronisers: stage one feeds stage two only
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_d_r;
  logic [4:0] pin_raw;
  assign pin_raw = {clear_key_i, edit_mode_i, led_clear_source_i,
                    relay_clear_source_i, scada_clear_source_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  logic key_s;
  logic edit_s;
  logic key_rise;
  logic led_ext_rise;
  logic rel_ext_rise;
  logic scada_ext_rise;
  assign key_s = pin_s2_r[4];
  assign edit_s = pin_s2_r[3];
  assign key_rise = rising(pin_s2_r[4], pin_d_r[4]);
  assign led_ext_rise = rising(pin_s2_r[2], pin_d_r[2]);
  assign rel_ext_rise = rising(pin_s2_r[1], pin_d_r[1]);
  assign scada_ext_rise = rising(pin_s2_r[0], pin_d_r[0]);

  logic alarm_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_d_r <= 1'b0;
    end else begin
      alarm_d_r <= new_alarm_i;
    end
  end

  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [N_LED-1:0] ledcfg_r;
  logic [N_LED-1:0] ledcfg_nxt;
  logic [`ACK_IRQ_W-1:0] irq_st_r;
  logic [`ACK_IRQ_W-1:0] irq_st_nxt;
  logic [`ACK_IRQ_W-1:0] irq_en_r;
  logic [`ACK_IRQ_W-1:0] irq_en_nxt;
  logic wb_ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic wr_cmd;
  logic [31:0] wr_dat;
  logic wb_go;
  logic external_clear_enable;
  logic pw_empty;
  key_sel_t key_sel;
  clear_set_t cmd_set;

  assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  assign wr_dat = wb_dat_i;
  assign wr_cmd = wb_go & wb_we_i & (wb_adr_i == `ACK_REG_CMD) & wb_sel_i[0];
  assign external_clear_enable = ctrl_r[`ACK_CTRL_EXT_EN];
  assign pw_empty = ctrl_r[`ACK_CTRL_PW_EMPTY];
  assign key_sel = key_sel_t'(ctrl_r[`ACK_CTRL_KEYSEL_LO +: 2]);
  assign cmd_set = clear_set_t'(wr_dat[3:0]);

  // Acknowledge sequencer
  ack_state_t state_r;
  ack_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic lamp_green_r;
  logic lamp_green_nxt;
  clear_set_t chosen_r;
  clear_set_t chosen_nxt;
  clear_set_t key_clear;
  logic refused;
  logic lamp_done;
  clear_set_t immediate_set;

  always_comb begin
    unique case (key_sel)
      KEY_SEL_LEDS: immediate_set = '{leds: 1'b1, relays: 1'b0, scada: 1'b0, trip: 1'b0};
      KEY_SEL_LEDS_RELAYS: immediate_set = '{1'b1, 1'b1, 1'b0, 1'b0};
      KEY_SEL_ALL: immediate_set = '{1'b1, 1'b1, 1'b1, 1'b1};
      KEY_SEL_NONE: immediate_set = '{1'b0, 1'b0, 1'b0, 1'b0};
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    lamp_green_nxt = lamp_green_r;
    chosen_nxt = chosen_r;
    key_clear = '{1'b0, 1'b0, 1'b0, 1'b0};
    lamp_done = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (key_rise && !edit_s) begin
          if (key_sel == KEY_SEL_NONE) begin
            state_nxt = ST_SELECT;
          end else begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_SELECT: begin
        // Softkey choice arrives as a command word; confirm acts
        if (edit_s) begin
          state_nxt = ST_IDLE;
        end else if (wr_cmd && wr_dat[`ACK_CMD_CONFIRM]) begin
          chosen_nxt = cmd_set;
          cnt_nxt = '0;
          state_nxt = ST_PASS;
        end
      end
      ST_HOLD: begin
        if (!key_s || edit_s) begin
          state_nxt = ST_IDLE;
        end else if (cnt_r >= 32'(HOLD_CYC - 1)) begin
          chosen_nxt = immediate_set;
          cnt_nxt = '0;
          state_nxt = ST_PASS;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      ST_PASS: begin
        // Password check precedes any panel acknowledge
        if (edit_s) begin
          state_nxt = ST_IDLE;
        end else if (pw_empty || (wr_cmd && wr_dat[`ACK_CMD_PW_OK])) begin
          key_clear = chosen_r;
          lamp_green_nxt = 1'b0;
          state_nxt = (key_sel == KEY_SEL_NONE) ? ST_IDLE : ST_LAMP;
        end
      end
      ST_LAMP: begin
        if (cnt_r >= 32'(LAMP_CYC - 1)) begin
          cnt_nxt = '0;
          if (lamp_green_r) begin
            lamp_done = 1'b1;
            lamp_green_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end else begin
            lamp_green_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      lamp_green_r <= 1'b0;
      chosen_r <= '{1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      lamp_green_r <= lamp_green_nxt;
      chosen_r <= chosen_nxt;
    end
  end

  // Clear sources, gated by edit mode (remote and pin clears also by external enable), ORed
  logic remote_ok;
  logic clr_led;
  logic clr_rel;
  logic clr_scada;
  logic clr_trip;
  logic auto_led;
  logic any_clear;
  assign remote_ok = wr_cmd && wr_dat[`ACK_CMD_REMOTE] && external_clear_enable;
  assign auto_led = rising(new_alarm_i, alarm_d_r) && !edit_s;
  assign clr_led = !edit_s && (key_clear.leds || (remote_ok && cmd_set.leds)
                   || (external_clear_enable && led_ext_rise));
  assign clr_rel = !edit_s && (key_clear.relays || (remote_ok && cmd_set.relays)
                   || (external_clear_enable && rel_ext_rise));
  assign clr_scada = !edit_s && (key_clear.scada || (remote_ok && cmd_set.scada)
                     || (external_clear_enable && scada_ext_rise));
  assign clr_trip = !edit_s && (key_clear.trip || (remote_ok && cmd_set.trip));
  assign any_clear = clr_led | clr_rel | clr_scada | clr_trip | auto_led;
  assign refused = edit_s && (key_rise || led_ext_rise || rel_ext_rise || scada_ext_rise
                   || (wr_cmd && wr_dat[`ACK_CMD_REMOTE]));

  logic [N_LED-1:0] led_mask;
  logic led_clr_any;
  // Manual clears take every LED; alarm clears only alarm-cleared ones
  assign led_mask = clr_led ? {N_LED{1'b1}} : ledcfg_r;
  assign led_clr_any = clr_led | auto_led;

  logic [N_LED-1:0] led_lat;
  ack_latch_bank #(.N(N_LED)) u_led (
    .clk_i(clk_i), .rst_i(rst_i), .cause_i(led_cause_i),
    .clear_mask_i(led_mask), .clear_i(led_clr_any), .latched_o(led_lat)
  );
  ack_latch_bank #(.N(N_REL)) u_rel (
    .clk_i(clk_i), .rst_i(rst_i), .cause_i(relay_cause_i),
    .clear_mask_i({N_REL{1'b1}}), .clear_i(clr_rel), .latched_o(relay_o)
  );
  ack_latch_bank #(.N(N_SCADA)) u_scada (
    .clk_i(clk_i), .rst_i(rst_i), .cause_i(scada_cause_i),
    .clear_mask_i({N_SCADA{1'b1}}), .clear_i(clr_scada), .latched_o(scada_o)
  );
  ack_latch_bank #(.N(1)) u_trip (
    .clk_i(clk_i), .rst_i(rst_i), .cause_i(trip_cause_i),
    .clear_mask_i(1'b1), .clear_i(clr_trip), .latched_o(trip_pending_o)
  );

  // Lamp test overrides the LED outputs
  assign led_o = (state_r == ST_LAMP) ? {N_LED{1'b1}} : led_lat;
  assign lamp_red_o = (state_r == ST_LAMP) && !lamp_green_r;
  assign lamp_green_o = (state_r == ST_LAMP) && lamp_green_r;

  // Register file and interrupts
  logic [`ACK_IRQ_W-1:0] irq_ev;
  logic wr_en;
  assign irq_ev = {lamp_done, refused, any_clear};
  assign wr_en = wb_go & wb_we_i & wb_sel_i[0];

  always_comb begin
    ctrl_nxt = ctrl_r;
    ledcfg_nxt = ledcfg_r;
    irq_en_nxt = irq_en_r;
    irq_st_nxt = irq_st_r;
    rdat_nxt = '0;
    if (wr_en && wb_adr_i == `ACK_REG_CTRL) begin
      ctrl_nxt = {28'h0, wr_dat[3:0]};
    end
    if (wr_en && wb_adr_i == `ACK_REG_LEDCFG) begin
      ledcfg_nxt = wr_dat[N_LED-1:0];
    end
    if (wr_en && wb_adr_i == `ACK_REG_IRQ_EN) begin
      irq_en_nxt = wr_dat[`ACK_IRQ_W-1:0];
    end
    if (wr_en && wb_adr_i == `ACK_REG_IRQ_CLR) begin
      irq_st_nxt = irq_st_r & ~wr_dat[`ACK_IRQ_W-1:0];
    end
    // Set wins over a same-cycle clear
    irq_st_nxt = irq_st_nxt | irq_ev;
    unique case (wb_adr_i)
      `ACK_REG_CTRL: rdat_nxt = ctrl_r;
      `ACK_REG_LEDCFG: rdat_nxt = 32'(ledcfg_r);
      `ACK_REG_STATUS: rdat_nxt = {26'h0, state_r, irq_st_r};
      `ACK_REG_IRQ_EN: rdat_nxt = {29'h0, irq_en_r};
      `ACK_REG_LATCH: rdat_nxt = {trip_pending_o, 15'h0, 8'(relay_o), 8'(led_lat)};
      default: rdat_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `ACK_CTRL_RESET;
      ledcfg_r <= '0;
      irq_en_r <= '0;
      irq_st_r <= '0;
      wb_ack_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ledcfg_r <= ledcfg_nxt;
      irq_en_r <= irq_en_nxt;
      irq_st_r <= irq_st_nxt;
      wb_ack_r <= wb_go;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_o = |(irq_st_r & irq_en_r);
endmodule : latched_ack

//--- verif/ack_monitor.sv
// Port-level checks for the acknowledge block
`timescale 1ns/100ps
module ack_monitor #(
  parameter int N_LED = 8,
  parameter int N_REL = 6,
  parameter int LAMP_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [N_LED-1:0] led_o,
  input wire logic lamp_red_o,
  input wire logic lamp_green_o,
  input wire logic [N_REL-1:0] relay_cause_i,
  input wire logic [N_REL-1:0] relay_o
);
  int red_r, red_nxt, grn_r, grn_nxt;
  // Phase lengths exceed what a repetition can hold, so count them
  always_comb begin
    red_nxt = (lamp_red_o && !rst_i) ? red_r + 1 : 0;
    grn_nxt = (lamp_green_o && !rst_i) ? grn_r + 1 : 0;
  end
  always_ff @(posedge clk_i) begin
    red_r <= red_nxt;
    grn_r <= grn_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_red_end;
    $fell(lamp_red_o);
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  lamp_excl_a: assert property (!(lamp_red_o && lamp_green_o))
    else $error("both lamp phases on");
  lamp_leds_a: assert property ((lamp_red_o || lamp_green_o) |-> (&led_o))
    else $error("leds not all on in lamp test");
  red_len_a: assert property (s_red_end |-> red_r == LAMP_CYC)
    else $error("red phase length wrong");
  red_green_a: assert property (s_red_end |-> lamp_green_o)
    else $error("green phase does not follow red");
  green_len_a: assert property ($fell(lamp_green_o) |-> grn_r == LAMP_CYC)
    else $error("green phase length wrong");
  relay_hold_a: assert property ((relay_o & $past(relay_cause_i)) == $past(relay_cause_i))
    else $error("relay with live cause not set");
endmodule : ack_monitor

bind latched_ack ack_monitor #(.N_LED(N_LED), .N_REL(N_REL), .LAMP_CYC(LAMP_CYC)) mon_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .led_o(led_o), .lamp_red_o(lamp_red_o), .lamp_green_o(lamp_green_o),
  .relay_cause_i(relay_cause_i), .relay_o(relay_o));

//--- verif/panel_model.sv
// Operator panel and assigned clear pins
`timescale 1ns/100ps
module panel_model (
  input wire logic clk_i,
  output logic clear_key_o,
  output logic edit_mode_o,
  output logic [2:0] src_o
);
  initial begin
    clear_key_o = 1'b0;
    edit_mode_o = 1'b0;
    src_o = 3'h0;
  end
  task automatic press(input int n);
    clear_key_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    clear_key_o <= 1'b0;
    @(posedge clk_i);
  endtask : press
  // Wider than the synchroniser, or the edge is lost
  task automatic pulse(input logic [2:0] s);
    src_o <= s;
    repeat (4) @(posedge clk_i);
    src_o <= 3'h0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  task automatic edit(input logic on);
    edit_mode_o <= on;
    repeat (4) @(posedge clk_i);
  endtask : edit
endmodule : panel_model

//--- verif/tb_top.sv
// Self-checking bench for the acknowledge block
`timescale 1ns/100ps
`include "ack_params.svh"
module tb_top;
  import ack_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clear_key_i, edit_mode_i;
  logic new_alarm_i, trip_cause_i, lamp_red_o, lamp_green_o, trip_pending_o, irq_o;
  logic [2:0] src;
  logic [7:0] wb_adr_i, led_cause_i, led_o, scada_cause_i, scada_o;
  logic [5:0] relay_cause_i, relay_o;
  logic [3:0] wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int err_count, comparisons;
  wire [31:0] outs = {9'h0, trip_pending_o, scada_o, relay_o, led_o};
  latched_ack #(.HOLD_CYC(20), .LAMP_CYC(10)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .clear_key_i,
    .edit_mode_i, .led_clear_source_i(src[0]), .relay_clear_source_i(src[1]),
    .scada_clear_source_i(src[2]), .new_alarm_i, .led_cause_i, .relay_cause_i,
    .scada_cause_i, .trip_cause_i, .led_o, .lamp_red_o, .lamp_green_o, .relay_o,
    .scada_o, .trip_pending_o, .irq_o);
  panel_model pan_u (.clk_i, .clear_key_o(clear_key_i), .edit_mode_o(edit_mode_i),
    .src_o(src));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel_v;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Causes are one-cycle pulses, so only the latch keeps them
  task automatic fire(input logic [22:0] c);
    {trip_cause_i, scada_cause_i, relay_cause_i, led_cause_i} <= c;
    @(posedge clk_i);
    {trip_cause_i, scada_cause_i, relay_cause_i, led_cause_i} <= 23'h0;
    repeat (2) @(posedge clk_i);
  endtask : fire
  task automatic t_reset;
    wb(1'b0, `ACK_REG_CTRL, 0);
    chk(rd, `ACK_CTRL_RESET);
    // Write without byte lane 0 is acknowledged but must not land
    sel_v = 4'hE;
    wb(1'b1, `ACK_REG_CTRL, 32'h0);
    sel_v = 4'hF;
    wb(1'b0, `ACK_REG_CTRL, 0);
    chk(rd, `ACK_CTRL_RESET);
    wb(1'b0, `ACK_REG_STATUS, 0);
    chk(rd, 32'h0);
    wb(1'b0, 8'hFC, 0);
    chk(rd, 32'h0);
    chk(outs, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ext;
    fire(23'h7FFFFF);
    chk(outs, 32'h7FFFFF);
    relay_cause_i <= 6'h01;
    pan_u.pulse(3'h7);
    chk(outs, 32'h400100);
    relay_cause_i <= 6'h00;
    wb(1'b1, `ACK_REG_CTRL, 32'h0);
    fire(23'h7FFFFF);
    pan_u.pulse(3'h7);
    chk(outs, 32'h7FFFFF);
    wb(1'b1, `ACK_REG_CMD, 32'h4F);
    repeat (4) @(posedge clk_i);
    chk(outs, 32'h7FFFFF);
    wb(1'b1, `ACK_REG_CTRL, 32'h1);
    wb(1'b1, `ACK_REG_CMD, 32'h4F);
    repeat (4) @(posedge clk_i);
    chk(outs, 32'h0);
    $display("external test done");
  endtask : t_ext
  task automatic t_alarm;
    wb(1'b1, `ACK_REG_LEDCFG, 32'h0F);
    fire(23'h0000FF);
    new_alarm_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    new_alarm_i <= 1'b0;
    chk(outs, 32'hF0);
    $display("alarm test done");
  endtask : t_alarm
  task automatic t_select;
    wb(1'b1, `ACK_REG_CTRL, 32'h1);
    fire(23'h7FFFFF);
    pan_u.press(5);
    repeat (20) @(posedge clk_i);
    chk(outs, 32'h7FFFFF);
    wb(1'b1, `ACK_REG_CMD, 32'h26);
    wb(1'b1, `ACK_REG_CMD, 32'h10);
    repeat (4) @(posedge clk_i);
    chk(outs, 32'h4000FF);
    wb(1'b0, `ACK_REG_LATCH, 0);
    chk(rd, 32'h8000_00FF);
    $display("select test done");
  endtask : t_select
  task automatic t_key(input key_sel_t s, input logic pw_empty);
    int n;
    n = 0;
    wb(1'b1, `ACK_REG_CTRL, {28'h0, pw_empty, s, 1'b1});
    fire(23'h7FFFFF);
    pan_u.press(30);
    if (!pw_empty) begin
      repeat (10) @(posedge clk_i);
      chk(outs, 32'h7FFFFF);
      wb(1'b1, `ACK_REG_CMD, 32'h10);
    end
    while (lamp_green_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, lamp_green_o}, 32'h1);
    while (lamp_green_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk(outs, {9'h0, s != KEY_SEL_ALL, s != KEY_SEL_ALL ? 8'hFF : 8'h00,
      s == KEY_SEL_LEDS ? 6'h3F : 6'h00, 8'h00});
    $display("key test done");
  endtask : t_key
  task automatic t_edit;
    wb(1'b1, `ACK_REG_IRQ_EN, 32'h2);
    fire(23'h7FFFFF);
    pan_u.edit(1'b1);
    wb(1'b1, `ACK_REG_CMD, 32'h4F);
    pan_u.pulse(3'h7);
    pan_u.press(30);
    repeat (40) @(posedge clk_i);
    chk(outs, 32'h7FFFFF);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, `ACK_REG_IRQ_EN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, `ACK_REG_IRQ_EN, 32'h2);
    pan_u.edit(1'b0);
    wb(1'b1, `ACK_REG_IRQ_CLR, 32'h7);
    wb(1'b0, `ACK_REG_STATUS, 0);
    chk(rd & 32'h2, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    $display("edit test done");
  endtask : t_edit
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, new_alarm_i} = 4'h0;
    {trip_cause_i, scada_cause_i, relay_cause_i, led_cause_i} = 23'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    sel_v = 4'hF;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_ext;
    t_alarm;
    t_select;
    t_key(KEY_SEL_LEDS, 1'b0);
    t_key(KEY_SEL_LEDS_RELAYS, 1'b1);
    t_key(KEY_SEL_ALL, 1'b1);
    t_edit;
    end_of_test;
  end
  // Ample margin over the expected run of some hundreds of cycles
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
endmodule : tb_top
